// ===== ptps_defines.svh
/*
 * ptps_defines.svh: sizes and timing counts for the probe
 * trigger/playback sequencer.
 * assumes: included by bare name; clk_sys at 200 MHz.
 */
`ifndef PTPS_DEFINES_SVH
`define PTPS_DEFINES_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define PTPS_NUM_CH 8
`define PTPS_DEPTH 12288
`define PTPS_ADDR_W 14

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PTPS_CLK_MHZ 200
`define PTPS_MAX_RATE_KBPS 2500
`define PTPS_HIZ_RATE_KBPS 1000
`define PTPS_MIN_PER_CYC ((`PTPS_CLK_MHZ * 1000 + `PTPS_MAX_RATE_KBPS - 1) / `PTPS_MAX_RATE_KBPS)
`define PTPS_HIZ_PER_CYC ((`PTPS_CLK_MHZ * 1000 + `PTPS_HIZ_RATE_KBPS - 1) / `PTPS_HIZ_RATE_KBPS)
`define PTPS_HIZ_DLY_NS 100
`define PTPS_HIZ_DLY_CYC ((`PTPS_HIZ_DLY_NS * `PTPS_CLK_MHZ) / 1000)
`define PTPS_TCK_MAX_MHZ 20
`define PTPS_SWCLK_MAX_MHZ 10
`define PTPS_TCK_DIV ((`PTPS_CLK_MHZ + 2 * `PTPS_TCK_MAX_MHZ - 1) / (2 * `PTPS_TCK_MAX_MHZ))
`define PTPS_SWCLK_DIV ((`PTPS_CLK_MHZ + 2 * `PTPS_SWCLK_MAX_MHZ - 1) / (2 * `PTPS_SWCLK_MAX_MHZ))
`define PTPS_BLINK_CYC 24'h989680

`endif

// ===== ptps_drive_stage.sv
/*
 * ptps_drive_stage.sv: one channel's output stage with delayed release.
 * assumes: sample strobe arrives at most once per sample period.
 */
`timescale 1ns/1ps
`include "ptps_defines.svh"

module ptps_drive_stage (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // sample
   input wire logic load,
   input wire logic [1:0] level,
   // pin
   output logic pin_o,
   output logic pin_oe_n
);
   logic pin_r, pin_nxt;
   logic oe_n_r, oe_n_nxt;
   logic [7:0] dly_r, dly_nxt;

   always_comb begin
      pin_nxt = pin_r;
      oe_n_nxt = oe_n_r;
      dly_nxt = dly_r;
      if (load) begin
         if (level == ptps_pkg::PTPS_DRV_HIZ) begin
            if (!oe_n_r) begin
               dly_nxt = 8'(`PTPS_HIZ_DLY_CYC);
            end
         end else begin
            dly_nxt = 8'h00;
            oe_n_nxt = 1'b0;
            pin_nxt = level[0];
         end
      end else if (dly_r != 8'h00) begin
         dly_nxt = dly_r - 8'h01;
         if (dly_r == 8'h01) begin
            oe_n_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pin_r <= 1'b0;
         oe_n_r <= 1'b1;
         dly_r <= 8'h00;
      end else if (clk_en) begin
         pin_r <= pin_nxt;
         oe_n_r <= oe_n_nxt;
         dly_r <= dly_nxt;
      end
   end

   assign pin_o = pin_r;
   assign pin_oe_n = oe_n_r;

   AST_HIZ_DELAY: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && load && level == ptps_pkg::PTPS_DRV_HIZ && !oe_n_r) ##1 clk_en
      |-> !pin_oe_n)
      else $error("release happened without delay");
endmodule : ptps_drive_stage

// ===== ptps_far_model.sv
/*
 * ptps_far_model.sv: target-side programming engine and a linked unit's clock.
 * assumes: shares clk_sys; each job ends in one done or one error pulse.
 */
`timescale 1ns/1ps

module ptps_far_model (
   // clock
   input wire logic clk_sys,
   // programming engine
   input wire logic replay_start,
   input wire logic fail_next,
   input wire logic [7:0] job_len,
   output logic replay_done,
   output logic replay_error,
   // linked unit
   input wire logic peer_clk_en,
   output logic peer_clk
);
   logic [7:0] left_r = 8'h00;

   // job lasts job_len cycles, then one result pulse
   always @(posedge clk_sys) begin
      replay_done <= 1'b0;
      replay_error <= 1'b0;
      peer_clk <= peer_clk_en & ~peer_clk; // still when not in use
      if (replay_start === 1'b1) begin
         left_r <= job_len;
      end else if (left_r != 8'h00) begin
         left_r <= left_r - 8'h01;
         replay_done <= (left_r == 8'h01) & ~fail_next;
         replay_error <= (left_r == 8'h01) & fail_next;
      end
   end
endmodule : ptps_far_model

// ===== ptps_pattern_store.sv
/*
 * ptps_pattern_store.sv: per-channel sample store, one entry per address.
 * assumes: writes come from host or captured analyzer data.
 */
`timescale 1ns/1ps
`include "ptps_defines.svh"

module ptps_pattern_store (
   // clock
   input wire logic clk_sys,
   input wire logic clk_en,
   // write side
   input wire logic wr_en,
   input wire logic [`PTPS_ADDR_W-1:0] wr_addr,
   input wire logic [2*`PTPS_NUM_CH-1:0] wr_data,
   // read side
   input wire logic [`PTPS_ADDR_W-1:0] rd_addr,
   output logic [2*`PTPS_NUM_CH-1:0] rd_data
);
   genvar g;
   generate
      for (g = 0; g < `PTPS_NUM_CH; g++) begin : g_ch
         logic [1:0] mem [0:`PTPS_DEPTH-1];
         logic [1:0] q_r;
         always_ff @(posedge clk_sys) begin
            if (clk_en) begin
               if (wr_en) begin
                  mem[wr_addr] <= wr_data[2*g +: 2];
               end
               q_r <= mem[rd_addr];
            end
         end
         assign rd_data[2*g +: 2] = q_r;
      end
   endgenerate
endmodule : ptps_pattern_store

// ===== ptps_pkg.sv
/*
 * ptps_pkg.sv: types for the probe trigger/playback sequencer.
 * assumes: nothing beyond the defines header.
 */
package ptps_pkg;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PTPS_FN_DEBUG_ADAPTER = 3'h0,
      PTPS_FN_BOUNDARY = 3'h1,
      PTPS_FN_ANALYZER = 3'h2,
      PTPS_FN_PLAYER = 3'h3,
      PTPS_FN_PROGRAM = 3'h4
   } ptps_func_type;

   typedef enum logic [1:0] {
      PTPS_DRV_LOW = 2'h0,
      PTPS_DRV_HIGH = 2'h1,
      PTPS_DRV_HIZ = 2'h2
   } ptps_drive_type;

   typedef enum logic [1:0] {
      PTPS_PL_IDLE = 2'h0,
      PTPS_PL_ARMED = 2'h1,
      PTPS_PL_RUN = 2'h3
   } ptps_play_type;

   typedef enum logic [1:0] {
      PTPS_SQ_IDLE = 2'h0,
      PTPS_SQ_RUN = 2'h1,
      PTPS_SQ_DONE = 2'h3
   } ptps_seq_type;
endpackage : ptps_pkg

// ===== ptps_sequencer.sv
/*
 * ptps_sequencer.sv: probe output functions: waveform player, connector
 * trigger pins, unit link lines and stand-alone programming sequencer.
 * assumes: the debug engine, nonvolatile store and analyzer core are outside;
 * pins are synchronous to clk_sys; open-drain pins resolved by the testbench.
 */
`timescale 1ns/1ps
`include "ptps_defines.svh"

module ptps_sequencer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // configuration
   input wire logic [2:0] func_sel,
   input wire logic [15:0] sample_period,
   input wire logic analyzer_rising,
   input wire logic program_level_start,
   input wire logic link_master,
   input wire logic link_clk_src,
   // pattern load
   input wire logic pat_wr_en,
   input wire logic [13:0] pat_wr_addr,
   input wire logic [15:0] pat_wr_data,
   input wire logic cap_wr_en,
   input wire logic [13:0] cap_wr_addr,
   input wire logic [15:0] cap_wr_data,
   input wire logic [13:0] pat_length,
   // waveform outputs
   output logic [7:0] wave_o,
   output logic [7:0] wave_oe_n,
   output logic play_busy,
   // connector pins
   input wire logic start_trigger_in,
   output logic event_trigger_out,
   output logic error_out,
   // analyzer core
   input wire logic analyzer_int_trig,
   output logic analyzer_ext_trig,
   // link lines
   input wire logic unit_sample_clk,
   input wire logic unit_clock_line_a_i,
   output logic unit_clock_line_a_o,
   output logic unit_clock_line_a_oe_n,
   input wire logic unit_clock_line_b_i,
   output logic unit_clock_line_b_o,
   output logic unit_clock_line_b_oe_n,
   input wire logic unit_trigger_line_a_i,
   output logic unit_trigger_line_a_o,
   output logic unit_trigger_line_a_oe_n,
   input wire logic unit_trigger_line_b_i,
   output logic unit_trigger_line_b_o,
   output logic unit_trigger_line_b_oe_n,
   output logic link_clock_rx,
   output logic link_trigger_rx,
   // programming engine
   input wire logic host_present,
   input wire logic prog_step_valid,
   output logic record_en,
   input wire logic run_button,
   output logic replay_start,
   input wire logic replay_done,
   input wire logic replay_error,
   input wire logic swd_sel,
   output logic [7:0] dbg_clk_div,
   // indicators
   output logic status_led,
   output logic error_led
);
   // ---------------------------------------------------------------
   // edges and mode decode
   // ---------------------------------------------------------------
   logic trg_d_r, run_d_r, ext_d_r;
   logic trg_fall, ext_edge, run_press;
   logic in_player, in_analyzer, in_program;

   assign in_player = (func_sel == ptps_pkg::PTPS_FN_PLAYER);
   assign in_analyzer = (func_sel == ptps_pkg::PTPS_FN_ANALYZER);
   assign in_program = (func_sel == ptps_pkg::PTPS_FN_PROGRAM);
   assign trg_fall = trg_d_r && !start_trigger_in;
   assign run_press = run_button && !run_d_r;

   logic ext_src;
   assign ext_src = link_master ? start_trigger_in : 1'b1;
   assign ext_edge = analyzer_rising ? (ext_src && !ext_d_r)
                                     : (!ext_src && ext_d_r);

   // ---------------------------------------------------------------
   // waveform player
   // ---------------------------------------------------------------
   ptps_pkg::ptps_play_type pl_r, pl_nxt;
   logic [13:0] rd_addr_r, rd_addr_nxt;
   logic [15:0] tick_r, tick_nxt;
   logic load_r, load_nxt;
   logic [15:0] rd_data;
   logic [15:0] eff_period;
   logic hiz_ok;

   assign eff_period = (sample_period < 16'(`PTPS_MIN_PER_CYC))
                       ? 16'(`PTPS_MIN_PER_CYC) : sample_period;
   assign hiz_ok = (eff_period >= 16'(`PTPS_HIZ_PER_CYC));

   always_comb begin
      pl_nxt = pl_r;
      rd_addr_nxt = rd_addr_r;
      tick_nxt = tick_r;
      load_nxt = 1'b0;
      case (pl_r)
         ptps_pkg::PTPS_PL_IDLE: begin
            if (in_player) begin
               pl_nxt = ptps_pkg::PTPS_PL_ARMED;
            end
         end
         ptps_pkg::PTPS_PL_ARMED: begin
            rd_addr_nxt = 14'h0000;
            if (!in_player) begin
               pl_nxt = ptps_pkg::PTPS_PL_IDLE;
            end else if (trg_fall) begin
               pl_nxt = ptps_pkg::PTPS_PL_RUN;
               tick_nxt = 16'h0000;
            end
         end
         ptps_pkg::PTPS_PL_RUN: begin
            if (!in_player) begin
               pl_nxt = ptps_pkg::PTPS_PL_IDLE;
            end else if (tick_r == 16'h0000) begin
               tick_nxt = eff_period - 16'h0001;
               load_nxt = 1'b1;
            end else begin
               tick_nxt = tick_r - 16'h0001;
               if (tick_r == 16'h0001) begin
                  if (rd_addr_r + 14'h0001 >= pat_length) begin
                     pl_nxt = ptps_pkg::PTPS_PL_ARMED;
                  end else begin
                     rd_addr_nxt = rd_addr_r + 14'h0001;
                  end
               end
            end
         end
         default: pl_nxt = ptps_pkg::PTPS_PL_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pl_r <= ptps_pkg::PTPS_PL_IDLE;
         rd_addr_r <= 14'h0000;
         tick_r <= 16'h0000;
         load_r <= 1'b0;
      end else if (clk_en) begin
         pl_r <= pl_nxt;
         rd_addr_r <= rd_addr_nxt;
         tick_r <= tick_nxt;
         load_r <= load_nxt;
      end
   end

   assign play_busy = (pl_r == ptps_pkg::PTPS_PL_RUN);

   ptps_pattern_store u_store (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .wr_en(pat_wr_en || cap_wr_en),
      .wr_addr(cap_wr_en ? cap_wr_addr : pat_wr_addr),
      .wr_data(cap_wr_en ? cap_wr_data : pat_wr_data),
      .rd_addr(rd_addr_r),
      .rd_data(rd_data)
   );

   genvar g;
   generate
      for (g = 0; g < `PTPS_NUM_CH; g++) begin : g_drv
         logic [1:0] lvl;
         assign lvl = (rd_data[2*g +: 2] == ptps_pkg::PTPS_DRV_HIZ && !hiz_ok)
                      ? ptps_pkg::PTPS_DRV_LOW : rd_data[2*g +: 2];
         ptps_drive_stage u_drv (
            .clk_sys(clk_sys),
            .reset(reset),
            .clk_en(clk_en),
            .load(load_r && in_player),
            .level(lvl),
            .pin_o(wave_o[g]),
            .pin_oe_n(wave_oe_n[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // stand-alone sequencer
   // ---------------------------------------------------------------
   ptps_pkg::ptps_seq_type sq_r, sq_nxt;
   logic [23:0] blink_r, blink_nxt;
   logic status_r, status_nxt;
   logic err_led_r, err_led_nxt;
   logic start_req_r, start_req_nxt;
   logic trg_out_r, trg_out_nxt;
   logic err_out_r, err_out_nxt;
   logic prog_go;

   assign prog_go = in_program && (program_level_start ? !start_trigger_in
                                                      : trg_fall);

   always_comb begin
      sq_nxt = sq_r;
      blink_nxt = blink_r;
      status_nxt = status_r;
      err_led_nxt = err_led_r;
      start_req_nxt = 1'b0;
      trg_out_nxt = 1'b1;
      err_out_nxt = 1'b1;
      case (sq_r)
         ptps_pkg::PTPS_SQ_IDLE,
         ptps_pkg::PTPS_SQ_DONE: begin
            if (!host_present && (run_press || prog_go)) begin
               sq_nxt = ptps_pkg::PTPS_SQ_RUN;
               start_req_nxt = 1'b1;
               status_nxt = 1'b0;
               err_led_nxt = 1'b0;
               blink_nxt = 24'h000000;
            end
         end
         ptps_pkg::PTPS_SQ_RUN: begin
            if (blink_r >= `PTPS_BLINK_CYC - 24'h000001) begin
               blink_nxt = 24'h000000;
               status_nxt = !status_r;
            end else begin
               blink_nxt = blink_r + 24'h000001;
            end
            if (replay_error) begin
               sq_nxt = ptps_pkg::PTPS_SQ_DONE;
               status_nxt = 1'b0;
               err_led_nxt = 1'b1;
               err_out_nxt = !in_program;
            end else if (replay_done) begin
               sq_nxt = ptps_pkg::PTPS_SQ_DONE;
               status_nxt = 1'b1;
               trg_out_nxt = !in_program;
            end
         end
         default: sq_nxt = ptps_pkg::PTPS_SQ_IDLE;
      endcase
      if (in_analyzer && analyzer_int_trig) begin
         trg_out_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sq_r <= ptps_pkg::PTPS_SQ_IDLE;
         blink_r <= 24'h000000;
         status_r <= 1'b0;
         err_led_r <= 1'b0;
         start_req_r <= 1'b0;
         trg_out_r <= 1'b1;
         err_out_r <= 1'b1;
         trg_d_r <= 1'b1;
         run_d_r <= 1'b0;
         ext_d_r <= 1'b1;
      end else if (clk_en) begin
         sq_r <= sq_nxt;
         blink_r <= blink_nxt;
         status_r <= status_nxt;
         err_led_r <= err_led_nxt;
         start_req_r <= start_req_nxt;
         trg_out_r <= trg_out_nxt;
         err_out_r <= err_out_nxt;
         trg_d_r <= start_trigger_in;
         run_d_r <= run_button;
         ext_d_r <= ext_src;
      end
   end

   assign event_trigger_out = trg_out_r;
   assign error_out = err_out_r;
   assign replay_start = start_req_r;
   assign status_led = status_r;
   assign error_led = err_led_r;
   assign record_en = host_present && in_program && prog_step_valid;
   assign dbg_clk_div = swd_sel ? 8'(`PTPS_SWCLK_DIV) : 8'(`PTPS_TCK_DIV);
   assign analyzer_ext_trig = in_analyzer && link_master && ext_edge;

   // ---------------------------------------------------------------
   // unit link lines
   // ---------------------------------------------------------------
   logic trig_share;
   assign trig_share = in_analyzer && (analyzer_int_trig || analyzer_ext_trig);
   assign unit_clock_line_a_o = unit_sample_clk;
   assign unit_clock_line_b_o = unit_sample_clk;
   assign unit_clock_line_a_oe_n = !(link_master && !link_clk_src);
   assign unit_clock_line_b_oe_n = !(link_master && link_clk_src);
   assign link_clock_rx = link_clk_src ? unit_clock_line_b_i : unit_clock_line_a_i;
   assign unit_trigger_line_a_o = 1'b0;
   assign unit_trigger_line_b_o = 1'b0;
   assign unit_trigger_line_a_oe_n = !trig_share;
   assign unit_trigger_line_b_oe_n = !trig_share;
   assign link_trigger_rx = !unit_trigger_line_a_i || !unit_trigger_line_b_i;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_PLAY_START: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && in_player && pl_r == ptps_pkg::PTPS_PL_ARMED && trg_fall)
      |=> play_busy || !clk_en)
      else $error("player did not start on trigger fall");
   AST_IDLE_PINS: assert property (@(posedge clk_sys) disable iff (reset)
      (func_sel <= ptps_pkg::PTPS_FN_BOUNDARY) && $stable(func_sel)
      |=> event_trigger_out && error_out)
      else $error("connector pins active in adapter mode");
   AST_RATE_CAP: assert property (@(posedge clk_sys) disable iff (reset)
      load_r |-> tick_r >= 16'(`PTPS_MIN_PER_CYC) - 16'h0001)
      else $error("sample period below floor");
   AST_ERR_LED: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && sq_r == ptps_pkg::PTPS_SQ_RUN && replay_error)
      |=> error_led && !status_led)
      else $error("error indicator not lit");
   AST_OK_LED: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && sq_r == ptps_pkg::PTPS_SQ_RUN && !replay_error && replay_done)
      |=> status_led && !error_led)
      else $error("status indicator not steady");
   AST_CLEAR_NEW: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(replay_start) |-> !status_led && !error_led)
      else $error("indicators not cleared on new run");
   AST_DONE_PIN: assert property (@(posedge clk_sys) disable iff (reset)
      (clk_en && in_program && sq_r == ptps_pkg::PTPS_SQ_RUN && replay_done
       && !replay_error && !analyzer_int_trig) |=> !event_trigger_out)
      else $error("completion not shown on trigger-out");
   AST_DBG_CLK: assert property (@(posedge clk_sys)
      dbg_clk_div >= (swd_sel ? 8'h0A : 8'h05))
      else $error("debug clock too fast");

   CVR_PLAY: cover property (@(posedge clk_sys) disable iff (reset) $rose(play_busy));
   CVR_OK: cover property (@(posedge clk_sys) disable iff (reset) $rose(status_led));
   CVR_ERR: cover property (@(posedge clk_sys) disable iff (reset) $rose(error_led));
endmodule : ptps_sequencer

// ===== testbench.sv
/*
 * testbench.sv: self-checking bench for ptps_sequencer and its far side.
 * assumes: design files and ptps_far_model compiled first; clk_sys 200 MHz.
 */
`timescale 1ns/1ps

module testbench;
   logic clk_sys, reset, clk_en, analyzer_rising, program_level_start, link_master;
   logic link_clk_src, pat_wr_en, cap_wr_en, start_trigger_in, analyzer_int_trig;
   logic play_busy, event_trigger_out, error_out, analyzer_ext_trig, link_clock_rx;
   logic link_trigger_rx, host_present, prog_step_valid, record_en, run_button;
   logic replay_start, replay_done, replay_error, swd_sel, status_led, error_led;
   logic fail_next, peer_clk_en, peer_clk, peer_trig;
   logic unit_sample_clk = 1'b0;
   logic unit_clock_line_a_i, unit_clock_line_a_o, unit_clock_line_a_oe_n;
   logic unit_clock_line_b_i, unit_clock_line_b_o, unit_clock_line_b_oe_n;
   logic unit_trigger_line_a_i, unit_trigger_line_a_o, unit_trigger_line_a_oe_n;
   logic unit_trigger_line_b_i, unit_trigger_line_b_o, unit_trigger_line_b_oe_n;
   logic [2:0] func_sel;
   logic [15:0] sample_period, pat_wr_data, cap_wr_data;
   logic [13:0] pat_wr_addr, cap_wr_addr, pat_length;
   logic [7:0] wave_o, wave_oe_n, dbg_clk_div, job_len;
   logic [7:0] n_ext = 8'h00, n_evt = 8'h00, n_err = 8'h00, n_rs = 8'h00;
   int error_cnt = 0;
   int total_checks = 0;

   ptps_sequencer DUT (
      .clk_sys, .reset, .clk_en, .func_sel, .sample_period, .analyzer_rising,
      .program_level_start, .link_master, .link_clk_src, .pat_wr_en, .pat_wr_addr,
      .pat_wr_data, .cap_wr_en, .cap_wr_addr, .cap_wr_data, .pat_length, .wave_o,
      .wave_oe_n, .play_busy, .start_trigger_in, .event_trigger_out, .error_out,
      .analyzer_int_trig, .analyzer_ext_trig, .unit_sample_clk, .unit_clock_line_a_i,
      .unit_clock_line_a_o, .unit_clock_line_a_oe_n, .unit_clock_line_b_i,
      .unit_clock_line_b_o, .unit_clock_line_b_oe_n, .unit_trigger_line_a_i,
      .unit_trigger_line_a_o, .unit_trigger_line_a_oe_n, .unit_trigger_line_b_i,
      .unit_trigger_line_b_o, .unit_trigger_line_b_oe_n, .link_clock_rx,
      .link_trigger_rx, .host_present, .prog_step_valid, .record_en, .run_button,
      .replay_start, .replay_done, .replay_error, .swd_sel, .dbg_clk_div,
      .status_led, .error_led
   );

   ptps_far_model far (
      .clk_sys, .replay_start, .fail_next, .job_len, .replay_done, .replay_error,
      .peer_clk_en, .peer_clk
   );

   // open-drain link lines, pulled up when released
   assign unit_clock_line_a_i = unit_clock_line_a_oe_n | unit_clock_line_a_o;
   assign unit_clock_line_b_i = (unit_clock_line_b_oe_n | unit_clock_line_b_o)
      & (~peer_clk_en | peer_clk);
   assign unit_trigger_line_a_i = (unit_trigger_line_a_oe_n | unit_trigger_line_a_o)
      & ~peer_trig;
   assign unit_trigger_line_b_i = unit_trigger_line_b_oe_n | unit_trigger_line_b_o;

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      unit_sample_clk <= ~unit_sample_clk;
      if (analyzer_ext_trig === 1'b1) n_ext <= n_ext + 8'h01;
      if (replay_start === 1'b1) n_rs <= n_rs + 8'h01;
   end
   always @(negedge event_trigger_out) n_evt <= n_evt + 8'h01;
   always @(negedge error_out) n_err <= n_err + 8'h01;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR time %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [13:0] a, input logic [15:0] d, input logic cap);
      {pat_wr_en, cap_wr_en} = {~cap, cap};
      {pat_wr_addr, cap_wr_addr, pat_wr_data, cap_wr_data} = {a, a, d, d};
      tick(1);
   endtask : wr

   // start pin falls as internal trigger pulses for one cycle, then start pin rises
   task automatic toggle;
      {start_trigger_in, analyzer_int_trig} = 2'h1;
      tick(1);
      analyzer_int_trig = 1'b0;
      tick(3);
      start_trigger_in = 1'b1;
      tick(4);
   endtask : toggle

   task automatic run(input logic fail, input logic by_pin);
      {fail_next, job_len} = {fail, 8'h28};
      {run_button, start_trigger_in} = {2{~by_pin}};
      tick(2);
      {run_button, start_trigger_in} = 2'h1;
      tick(2);
      chk({status_led, error_led}, 2'h0);
      tick(60);
      chk({status_led, error_led}, {~fail, fail});
      chk({event_trigger_out, error_out}, 2'h3);
   endtask : run

   initial begin
      repeat (3000) @(posedge clk_sys);
      chk(32'h0, 32'h1);
      give_verdict();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      {pat_wr_en, cap_wr_en, analyzer_int_trig, run_button, host_present, prog_step_valid,
       swd_sel, fail_next, peer_clk_en, peer_trig, program_level_start, link_master,
       link_clk_src, analyzer_rising, func_sel, sample_period, pat_wr_addr, cap_wr_addr,
       pat_wr_data, cap_wr_data, pat_length, job_len} = '0;
      {reset, clk_en, start_trigger_in} = 3'h7;
      tick(5);
      reset = 1'b0;
      chk({event_trigger_out, error_out, wave_oe_n}, 10'h3FF);
      chk({status_led, error_led}, 2'h0);
      $display("test reset done");
      wr(14'h0000, 16'h5555, 1'b0);
      wr(14'h0001, 16'h0000, 1'b0);
      wr(14'h0002, 16'hAAAA, 1'b1);
      {pat_wr_en, cap_wr_en} = 2'h0;
      {sample_period, pat_length, func_sel} = {16'h00C8, 14'h0003, 3'h3};
      tick(3);
      start_trigger_in = 1'b0;
      tick(2);
      chk(play_busy, 1'b1);
      tick(8);
      chk({wave_o, wave_oe_n}, 16'hFF00);
      tick(90);
      start_trigger_in = 1'b1;
      tick(50);
      start_trigger_in = 1'b0;
      tick(60);
      chk({wave_o, wave_oe_n}, 16'h0000);
      tick(200);
      chk(wave_oe_n, 8'h00);
      tick(30);
      chk(wave_oe_n, 8'hFF);
      tick(180);
      chk(play_busy, 1'b0);
      start_trigger_in = 1'b1;
      $display("test player done");
      wr(14'h0000, 16'hAAAA, 1'b0);
      wr(14'h0001, 16'h5555, 1'b0);
      {pat_wr_en, sample_period, pat_length} = {1'b0, 16'h000A, 14'h0002};
      tick(3);
      start_trigger_in = 1'b0;
      tick(30);
      chk({wave_o, wave_oe_n}, 16'h0000);
      tick(60);
      chk({wave_o, wave_oe_n}, 16'hFF00);
      start_trigger_in = 1'b1;
      tick(100);
      $display("test rate done");
      {func_sel, link_master, analyzer_rising} = 5'h0B;
      tick(2);
      toggle();
      chk({n_ext, n_evt}, {8'h01, 8'h01});
      analyzer_rising = 1'b0;
      toggle();
      chk(n_ext, 8'h02);
      link_master = 1'b0;
      toggle();
      chk({n_ext, n_evt}, {8'h02, 8'h03});
      for (int f = 0; f < 2; f++) begin
         func_sel = f[2:0];
         toggle();
         chk({n_ext, n_evt, n_err}, {8'h02, 8'h03, 8'h00});
      end
      $display("test trigger done");
      {func_sel, link_clk_src, peer_clk_en} = 5'h0B;
      tick(2);
      chk(link_clock_rx, unit_clock_line_b_i);
      tick(1);
      chk({link_clock_rx, link_trigger_rx}, {unit_clock_line_b_i, 1'b0});
      {peer_clk_en, peer_trig} = 2'h1;
      tick(1);
      chk(link_trigger_rx, 1'b1);
      {peer_trig, link_master, link_clk_src} = 3'h2;
      tick(2);
      chk(unit_clock_line_a_oe_n, 1'b0);
      chk({unit_clock_line_b_oe_n, link_clock_rx}, {1'b1, unit_sample_clk});
      analyzer_int_trig = 1'b1;
      tick(1);
      chk({unit_trigger_line_a_oe_n, unit_trigger_line_b_oe_n, link_trigger_rx}, 3'h1);
      analyzer_int_trig = 1'b0;
      $display("test link done");
      {func_sel, host_present, prog_step_valid, link_master} = 6'h26;
      tick(1);
      chk(record_en, 1'b1);
      host_present = 1'b0;
      tick(1);
      chk({record_en, dbg_clk_div}, 9'h005);
      swd_sel = 1'b1;
      tick(1);
      chk(dbg_clk_div, 8'h0A);
      run(1'b0, 1'b0);
      run(1'b1, 1'b0);
      run(1'b0, 1'b1);
      {clk_en, run_button} = 2'h1;
      tick(3);
      chk({n_rs, status_led}, {8'h03, 1'b1});
      {clk_en, run_button, program_level_start} = 3'h5;
      run(1'b0, 1'b1);
      chk(n_rs, 8'h04);
      chk({n_evt, n_err}, {8'h07, 8'h01});
      $display("test program done");
      give_verdict();
   end
endmodule : testbench
